// >>> rtl/sbr_ctrl.sv
// standby and reset control: halt/stop modes, main clock stop bit, reset merge
`timescale 1ns/1ps
module sbr_ctrl #(
   parameter int STAB_CYC = sbr_pkg::OSC_STAB_CYC
) (
   input wire logic clk,                  // main system clock
   input wire logic rst_n,                // power-on reset, active low
   input wire logic reset_pin_n,          // external reset pin, active low
   input wire logic wdt_runaway,          // watchdog runaway pulse
   input wire logic irq_pending,          // unmasked interrupt request level
   input wire sbr_pkg::sbr_cmd_type cmd,  // cpu instruction and register write
   output sbr_pkg::sbr_ctl_type ctl,      // clock gates and reset out
   output logic [7:0] pcc_rdata,          // processor clock control readback
   output logic standby,                  // either standby mode active
   output logic stab_busy                 // stabilization wait running
);
   localparam int CW = $clog2(STAB_CYC + 1);
   localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYC - 1);

   sbr_pkg::sbr_state_type state_r, state_nxt;
   logic [7:0] pcc_r, pcc_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic wdt_rst_r;
   logic pin_sync;

   sbr_sync #(.RESET_VAL(1'b0)) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din(reset_pin_n),
      .dout(pin_sync)
   );

   // any reset source, pin or watchdog
   wire pin_rst = !pin_sync;
   wire any_rst = pin_rst || wdt_rst_r;
   wire on_sub = pcc_r[sbr_pkg::CPU_SUB_SEL_BIT];
   wire main_stopped = pcc_r[sbr_pkg::MAIN_STOP_BIT];
   wire stop_ok = cmd.stop_cmd && !main_stopped;
   wire stab_done = (cnt_r == STAB_LAST);
   // stop bit only lands while cpu stays on subsystem clock
   wire sub_wr_ok = !cmd.pcc_wdata[sbr_pkg::MAIN_STOP_BIT] ||
      (on_sub && cmd.pcc_wdata[sbr_pkg::CPU_SUB_SEL_BIT]);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      pcc_nxt = pcc_r;
      if (cmd.pcc_we && state_r == sbr_pkg::SBR_ST_RUN && sub_wr_ok) begin
         pcc_nxt = cmd.pcc_wdata;
      end
      case (state_r)
         sbr_pkg::SBR_ST_STAB: begin
            cnt_nxt = CW'(cnt_r + 1'b1);
            if (stab_done) begin
               state_nxt = sbr_pkg::SBR_ST_RUN;
            end
         end
         sbr_pkg::SBR_ST_RUN: begin
            if (stop_ok) begin
               state_nxt = sbr_pkg::SBR_ST_STOP;
            end else if (cmd.halt_cmd) begin
               state_nxt = sbr_pkg::SBR_ST_HALT;
            end
         end
         sbr_pkg::SBR_ST_HALT: begin
            if (irq_pending) begin
               state_nxt = sbr_pkg::SBR_ST_RUN;
            end
         end
         sbr_pkg::SBR_ST_STOP: begin
            if (irq_pending) begin
               state_nxt = sbr_pkg::SBR_ST_STAB;
               cnt_nxt = '0;
            end
         end
         default: begin
            state_nxt = sbr_pkg::SBR_ST_STAB;
            cnt_nxt = '0;
         end
      endcase
      if (any_rst) begin
         state_nxt = sbr_pkg::SBR_ST_STAB;
         cnt_nxt = '0;
         pcc_nxt = sbr_pkg::PCC_RESET;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= sbr_pkg::SBR_ST_STAB;
         cnt_r <= '0;
         pcc_r <= sbr_pkg::PCC_RESET;
         wdt_rst_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         pcc_r <= pcc_nxt;
         wdt_rst_r <= wdt_runaway;
      end
   end

   wire in_stop = (state_r == sbr_pkg::SBR_ST_STOP);
   wire in_halt = (state_r == sbr_pkg::SBR_ST_HALT);
   wire in_stab = (state_r == sbr_pkg::SBR_ST_STAB);
   wire osc_on = !in_stop && !main_stopped;
   wire sys_rst_n_int = !any_rst && !in_stab;

   always_comb begin
      ctl.cpu_clk_en = !in_halt && !in_stop && !in_stab;
      ctl.main_osc_en = osc_on;
      ctl.main_clk_en = osc_on && !in_stab;
      ctl.sub_clk_en = 1'b1;
      ctl.sys_rst_n = sys_rst_n_int;
   end

   assign pcc_rdata = pcc_r;
   assign standby = in_halt || in_stop;
   assign stab_busy = in_stab;

   a_halt_gates_cpu: assert property (@(posedge clk) disable iff (!rst_n)
      in_halt |-> !ctl.cpu_clk_en && (ctl.main_clk_en == !main_stopped))
      else $error("cpu clock not gated in halt");
   a_stop_osc_off: assert property (@(posedge clk) disable iff (!rst_n)
      in_stop |-> !ctl.main_osc_en && !ctl.main_clk_en)
      else $error("main oscillator running in stop");
   a_sub_runs: assert property (@(posedge clk) disable iff (!rst_n)
      in_stop |-> ctl.sub_clk_en)
      else $error("subsystem clock off in stop");
   a_mcc_stops_osc: assert property (@(posedge clk) disable iff (!rst_n)
      main_stopped |-> !ctl.main_osc_en && on_sub)
      else $error("main clock runs with stop bit set");
   a_stop_refused: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == sbr_pkg::SBR_ST_RUN && main_stopped && !any_rst && !cmd.halt_cmd)
      |=> state_r == sbr_pkg::SBR_ST_RUN)
      else $error("stop entered with main clock stopped");
   a_stab_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (in_stab && cnt_r == '0 && !any_rst) |-> !ctl.main_clk_en [*8])
      else $error("main clock used before stabilization");
   a_pin_reset: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(pin_sync) |=> in_stab && pcc_r == sbr_pkg::PCC_RESET)
      else $error("pin reset not taken");
   a_wdt_reset: assert property (@(posedge clk) disable iff (!rst_n)
      wdt_runaway |=> !ctl.sys_rst_n ##1 in_stab)
      else $error("watchdog reset not taken");
   a_halt_entry: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == sbr_pkg::SBR_ST_RUN && cmd.halt_cmd && !cmd.stop_cmd && !any_rst)
      |=> in_halt)
      else $error("halt instruction ignored");
   a_halt_wake: assert property (@(posedge clk) disable iff (!rst_n)
      (in_halt && irq_pending && !any_rst) |=> state_r == sbr_pkg::SBR_ST_RUN)
      else $error("halt not released by interrupt");
   a_stop_wake: assert property (@(posedge clk) disable iff (!rst_n)
      (in_stop && irq_pending && !any_rst) |=> in_stab && cnt_r == '0)
      else $error("stop not released by interrupt");
   a_rst_clears_pcc: assert property (@(posedge clk) disable iff (!rst_n)
      any_rst |=> pcc_r == sbr_pkg::PCC_RESET && in_stab)
      else $error("reset left control bits set");
endmodule

// >>> rtl/sbr_pkg.sv
// package for standby and reset control: constants, states, carriers
// Behaviour
// - halt mode gates the cpu clock while the rest of the chip runs
// - stop mode stops the main oscillator and all main-clocked functions
// - in stop mode only the subsystem clock keeps running
// - on subsystem clock, writing 1 to control bit 7 stops main clock
// - stop instruction is not usable while main clock is stopped by control bit
// - after reset or stop release, wait stabilization before using main clock
// - external reset pin asserted puts the device in reset
// - watchdog runaway detection generates an internal reset
// - subsystem clock is 32.768 kHz, 122 us instruction time
package sbr_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int SUB_CLK_HZ = 32768;
   localparam int SUB_INSN_NS = 122000;
   localparam int OSC_STAB_US = 4000;
   localparam int OSC_STAB_CYC = (OSC_STAB_US * (CLK_HZ / 1000000));
   localparam int MAIN_STOP_BIT = 7;
   localparam int CPU_SUB_SEL_BIT = 4;
   localparam logic [7:0] PCC_RESET = 8'h00;
   localparam int SYNC_STAGES = 3;

   typedef enum logic [2:0] {
      SBR_ST_STAB,
      SBR_ST_RUN,
      SBR_ST_HALT,
      SBR_ST_STOP
   } sbr_state_type;

   typedef struct packed {
      logic halt_cmd;
      logic stop_cmd;
      logic pcc_we;
      logic [7:0] pcc_wdata;
   } sbr_cmd_type;

   typedef struct packed {
      logic cpu_clk_en;
      logic main_osc_en;
      logic main_clk_en;
      logic sub_clk_en;
      logic sys_rst_n;
   } sbr_ctl_type;
endpackage

// >>> rtl/sbr_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module sbr_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,        // system clock
   input wire logic rst_n,      // async reset, active low
   input wire logic din,        // asynchronous input
   output logic dout            // filtered level
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic dout_r;
   wire agree = (s2_r == s3_r);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= RESET_VAL;
         s2_r <= RESET_VAL;
         s3_r <= RESET_VAL;
         dout_r <= RESET_VAL;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) begin
            dout_r <= s3_r;
         end
      end
   end

   assign dout = dout_r;
endmodule

// >>> verification/sbr_ctrl_bench.sv
// self-checking bench for standby and reset control
`timescale 1ns/1ps
module sbr_ctrl_bench;
   logic clk, rst_n, reset_pin_n, wdt_runaway, irq_pending, standby, stab_busy;
   sbr_pkg::sbr_cmd_type cmd;
   sbr_pkg::sbr_ctl_type ctl;
   logic [7:0] pcc_rdata;
   int failures, check_count, n;
   sbr_ctrl #(.STAB_CYC(16)) i_sbr_ctrl (.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
      .wdt_runaway(wdt_runaway), .irq_pending(irq_pending), .cmd(cmd), .ctl(ctl),
      .pcc_rdata(pcc_rdata), .standby(standby), .stab_busy(stab_busy));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one-cycle pulse on a command, settle in the answer cycle
   task automatic issue(input logic h, input logic s, input logic we, input logic [7:0] d);
      @(posedge clk) cmd <= '{h, s, we, d};
      @(posedge clk) cmd <= '0;
      #1;
   endtask
   task automatic pulse_irq;
      @(posedge clk) irq_pending <= 1'b1;
      @(posedge clk) irq_pending <= 1'b0;
      #1;
   endtask
   task automatic wait_run;
      n = 0;
      while (stab_busy !== 1'b0 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(n < 200, 1'b1);
      chk({ctl.cpu_clk_en, ctl.main_clk_en, ctl.sys_rst_n}, 3'b111);
   endtask
   task automatic t_halt;
      issue(1'b1, 1'b0, 1'b0, 8'h00);
      chk({standby, ctl.cpu_clk_en, ctl.main_osc_en, ctl.main_clk_en}, 4'b1011);
      pulse_irq();
      chk({standby, ctl.cpu_clk_en}, 2'b01);
   endtask
   task automatic t_stop;
      issue(1'b1, 1'b1, 1'b0, 8'h00);
      chk({standby, ctl.cpu_clk_en, ctl.main_osc_en, ctl.main_clk_en}, 4'b1000);
      chk(ctl.sub_clk_en, 1'b1);
      pulse_irq();
      chk({stab_busy, ctl.main_osc_en, ctl.main_clk_en}, 3'b110);
      n = 0;
      while (stab_busy === 1'b1 && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(n), 16'd16);
      chk({standby, ctl.cpu_clk_en, ctl.main_clk_en}, 3'b011);
   endtask
   task automatic t_mainstop;
      issue(1'b0, 1'b0, 1'b1, 8'h80);
      chk(pcc_rdata, 8'h00);
      issue(1'b0, 1'b0, 1'b1, 8'h10);
      chk(pcc_rdata, 8'h10);
      issue(1'b0, 1'b0, 1'b1, 8'h90);
      @(posedge clk);
      #1;
      chk({pcc_rdata, ctl.main_clk_en}, {8'h90, 1'b0});
      issue(1'b0, 1'b1, 1'b0, 8'h00);
      chk({standby, ctl.cpu_clk_en}, 2'b01);
      @(posedge clk) wdt_runaway <= 1'b1;
      @(posedge clk) wdt_runaway <= 1'b0;
      #1;
      chk(ctl.sys_rst_n, 1'b0);
      @(posedge clk);
      #1;
      chk(stab_busy, 1'b1);
      wait_run();
      chk(pcc_rdata, 8'h00);
   endtask
   task automatic t_pin;
      @(posedge clk) reset_pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk({ctl.sys_rst_n, stab_busy, ctl.cpu_clk_en}, 3'b010);
      @(posedge clk) reset_pin_n <= 1'b1;
      wait_run();
   endtask
   initial begin
      rst_n = 1'b0;
      reset_pin_n = 1'b1;
      wdt_runaway = 1'b0;
      irq_pending = 1'b0;
      cmd = '0;
      failures = 0;
      check_count = 0;
      repeat (2) @(posedge clk);
      #1;
      chk({stab_busy, ctl.sys_rst_n, ctl.cpu_clk_en, pcc_rdata}, {3'b100, 8'h00});
      rst_n = 1'b1;
      wait_run();
      t_halt();
      t_stop();
      t_mainstop();
      t_pin();
      close_out();
   end
   initial begin
      #(40 * 3000);
      failures++;
      close_out();
   end
endmodule
